//--- design/opssc_cmd_top.sv
// Command interpreter for display position, sprite, sync and table transfer.
//
// Summary of operation
// - Horizontal start: 7 bits, 8-dot steps.
// - Horizontal start sits about 100 dots after sync.
// - Sprite select maps to codes 1F8H..1FFH.
// - Background bit picks none or pattern background.
// - Sprite vertical: 9 bits, 2-dot steps.
// - Sprite horizontal: 9 bits, 2-dot steps.
// - Horizontal position zero hides the sprite.
// - Enable bit gates dot clock onto pin.
// - Prescaler divides by 2, 3, 5, 6.
// - Scan select; value 11 never used.
// - Line divisor in 16-dot units, up to 2032.
// - Start address bit 0 forced to 0.
// - Start address bytes load without starting.
// - End address bit 0 forced to 1.
// - Upper end-address command alone starts transfer.
// - Busy high from start until transfer ends.
// - Window bit: any blanking or vertical only.
// - Commands arrive as 16-bit serial transfers, two bytes under one chip select.
`timescale 1ns/1ps
module opssc_cmd_top
    import opssc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Host serial command port.
    input wire logic scs_n_i,
    input wire logic sclk_i,
    input wire logic sdata_i,
    // Blanking indications from the video timing pins.
    input wire logic hblank_i,
    input wire logic vblank_i,
    // Command-table memory port, one cycle read latency.
    output logic rom_rd_o,
    output logic [15:0] rom_addr_o,
    input wire logic [7:0] rom_data_i,
    // Display position settings.
    output logic [6:0] h_start_pos_o,
    output logic [10:0] h_start_dots_o,
    // Sprite settings.
    output logic [8:0] sprite_glyph_code_o,
    output logic [2:0] sprite_fg_color_o,
    output logic sprite_bg_select_o,
    output logic [2:0] sprite_bg_color_o,
    output logic [8:0] sprite_v_pos_o,
    output logic [8:0] sprite_h_pos_o,
    output logic [9:0] sprite_v_dots_o,
    output logic [9:0] sprite_h_dots_o,
    output logic sprite_enable_o,
    // Synchronisation settings.
    output logic dotclk_o,
    output logic [1:0] pixclk_div_sel_o,
    output logic [1:0] scan_type_sel_o,
    output logic [6:0] line_freq_divisor_o,
    output logic [10:0] line_div_ratio_o,
    // Transfer status.
    output logic xfer_window_sel_o,
    output logic xfer_busy_out_o
);

    // The whole state of the interpreter apart from the serial receiver.
    typedef struct packed {
        logic [1:0] hb_s;         // Horizontal blanking synchroniser.
        logic [1:0] vb_s;         // Vertical blanking synchroniser.
        logic ser_phase;          // Serial port holds a first byte.
        logic [7:0] ser_first;    // First serial byte of a pair.
        logic rom_phase;          // Table stream holds a first byte.
        logic [7:0] rom_first;    // First table byte of a pair.
        logic [6:0] h_start;      // Horizontal display start field.
        logic [2:0] glyph;        // Sprite glyph select.
        logic [2:0] fg;           // Sprite colour.
        logic bgsel;              // Sprite background mode.
        logic [2:0] bgc;          // Sprite background colour.
        logic [8:0] vpos;         // Sprite vertical position.
        logic [8:0] hpos;         // Sprite horizontal position.
        logic dot_en;             // Dot clock output enable.
        logic [1:0] div_sel;      // Prescaler select.
        logic [1:0] scan;         // Scan mode.
        logic [6:0] ldiv;         // Line frequency divisor.
        logic [15:0] sa;          // Transfer start address.
        logic [15:0] ea;          // Transfer end address.
        logic xfer_window_sel;                // Transfer window select.
        opssc_xs_t xs;            // Transfer state.
        logic [15:0] addr;        // Current table address.
        logic [15:0] xend;        // End address latched at start.
        logic xvbs;               // Window select latched at start.
        logic [2:0] dcnt;         // Prescaler counter.
        logic dot;                // Registered dot clock pin level.
        logic [10:0] h_dots;      // Horizontal start in dots.
        logic [8:0] code;         // Sprite character code.
        logic [9:0] v_dots;       // Sprite vertical position in dots.
        logic [9:0] h_dots_spr;   // Sprite horizontal position in dots.
        logic spr_en;             // Sprite display allowed.
        logic [10:0] lratio;      // Line divisor in dots.
    } opssc_state_t;

    opssc_state_t r;
    opssc_state_t n;

    logic rx_cs_active; // Chip select asserted, synchronised.
    logic rx_valid;     // One received byte, one-cycle pulse.
    logic [7:0] rx_byte; // Received byte.

    opssc_serial_rx u_rx (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .scs_n_i(scs_n_i),
        .sclk_i(sclk_i),
        .sdata_i(sdata_i),
        .cs_active_o(rx_cs_active),
        .byte_valid_o(rx_valid),
        .byte_o(rx_byte)
    );

    // Tests whether a first byte carries the given opcode.
    function automatic logic op_is(input logic [7:0] b, input logic [7:0] opc,
                                   input logic [7:0] msk);
        op_is = ((b & msk) == opc);
    endfunction

    // Applies one command pair to the settings held in a state record.
    function automatic opssc_state_t apply_cmd(input opssc_state_t s, input logic [7:0] b0,
                                               input logic [7:0] b1);
        opssc_state_t t;
        t = s;
        if (op_is(b0, OPC_HSTART, OPM_HSTART)) begin
            t.h_start = b1[6:0];
        end else if (op_is(b0, OPC_SPRITE, OPM_SPRITE)) begin
            t.glyph = b0[GLYPH_MSB:GLYPH_MSB-2];
            t.bgsel = b0[BGSEL_BIT];
            t.fg = b1[FG_MSB:FG_MSB-2];
            t.bgc = b1[BGC_MSB:BGC_MSB-2];
        end else if (op_is(b0, OPC_SPR_V, OPM_SPR_V)) begin
            t.vpos = {b0[1:0], b1[6:0]};
        end else if (op_is(b0, OPC_SPR_H, OPM_SPR_H)) begin
            t.hpos = {b0[1:0], b1[6:0]};
        end else if (op_is(b0, OPC_SYNC1, OPM_SYNC1)) begin
            t.dot_en = b0[DOT_BIT];
            t.div_sel = b1[3:2];
            if (b1[1:0] != SCAN_PROHIBITED) begin
                t.scan = b1[1:0];
            end
        end else if (op_is(b0, OPC_SYNC2, OPM_SYNC2)) begin
            t.ldiv = b1[6:0];
        end else if (op_is(b0, OPC_SA_LO, OPM_ADDR)) begin
            t.sa[7:0] = {b1[7:1], 1'b0};
        end else if (op_is(b0, OPC_SA_HI, OPM_ADDR)) begin
            t.sa[15:8] = b1;
        end else if (op_is(b0, OPC_EA_LO, OPM_ADDR)) begin
            t.ea[7:0] = {b1[7:1], 1'b1};
        end else if (op_is(b0, OPC_EA_HI, OPM_EA_HI)) begin
            // Window select stored with upper end byte.
            t.xfer_window_sel = b0[VBS_BIT];
            t.ea[15:8] = b1;
        end
        apply_cmd = t;
    endfunction

    // Prescaler ratio for the current select.
    logic [2:0] presc_ratio;
    // Transfer window currently open.
    logic window_open;

    // Ratio lookup and blanking window.
    always_comb begin
        case (r.div_sel)
            2'b00: presc_ratio = PRESC_DIV0;
            2'b01: presc_ratio = PRESC_DIV1;
            2'b10: presc_ratio = PRESC_DIV2;
            default: presc_ratio = PRESC_DIV3;
        endcase
        window_open = r.xvbs ? r.vb_s[1] : (r.vb_s[1] | r.hb_s[1]);
    end

    // Next-state logic: table stream first, then serial pairs.
    always_comb begin
        n = r;
        n.hb_s = {r.hb_s[0], hblank_i};
        n.vb_s = {r.vb_s[0], vblank_i};

        case (r.xs)
            XS_IDLE: begin
                n.xs = XS_IDLE;
            end
            XS_WAIT: begin
                // Wait for a blanking interval before each read.
                if (window_open) begin
                    n.xs = XS_READ;
                end
            end
            XS_READ: begin
                // Read strobe is out this cycle; data returns next cycle.
                n.xs = XS_TAKE;
            end
            XS_TAKE: begin
                // Bytes pair up and run as commands.
                if (!r.rom_phase) begin
                    n.rom_first = rom_data_i;
                    n.rom_phase = 1'b1;
                end else begin
                    n = apply_cmd(n, r.rom_first, rom_data_i);
                    n.rom_phase = 1'b0;
                end
                // Busy drops after the last byte.
                if (r.addr == r.xend) begin
                    n.xs = XS_IDLE;
                end else begin
                    n.addr = r.addr + 16'h0001;
                    n.xs = XS_WAIT;
                end
            end
            default: begin
                n.xs = XS_IDLE;
            end
        endcase

        // Serial pairs; a released chip select drops a half pair.
        if (!rx_cs_active) begin
            n.ser_phase = 1'b0;
        end else if (rx_valid) begin
            if (!r.ser_phase) begin
                n.ser_first = rx_byte;
                n.ser_phase = 1'b1;
            end else begin
                n.ser_phase = 1'b0;
                n = apply_cmd(n, r.ser_first, rx_byte);
                // Only the upper end-address command starts.
                if (op_is(r.ser_first, OPC_EA_HI, OPM_EA_HI) && (r.xs == XS_IDLE)) begin
                    n.addr = {n.sa[15:1], 1'b0};
                    n.xend = {n.ea[15:1], 1'b1};
                    n.xvbs = n.xfer_window_sel;
                    n.rom_phase = 1'b0;
                    n.xs = XS_WAIT;
                end
            end
        end

        // Internal dot clock from the prescaler.
        if (r.dcnt >= presc_ratio - 3'h1) begin
            n.dcnt = 3'h0;
        end else begin
            n.dcnt = r.dcnt + 3'h1;
        end
        // Dot clock reaches the pin only when enabled.
        n.dot = n.dot_en && (n.dcnt < {1'b0, presc_ratio[2:1]});

        n.h_dots = H_START_OFFSET + {1'b0, n.h_start, 3'b000};
        n.code = SPRITE_CODE_BASE | {6'h00, n.glyph};
        n.v_dots = {n.vpos, 1'b0};
        n.h_dots_spr = {n.hpos, 1'b0};
        n.spr_en = (n.hpos != RST_SPR_POS);
        n.lratio = {n.ldiv, 4'h0};
    end

    // State register.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Sprite off and no transfer after reset.
            r <= '{hb_s: 2'b00, vb_s: 2'b00, ser_phase: 1'b0, ser_first: 8'h00,
                   rom_phase: 1'b0, rom_first: 8'h00, h_start: RST_H_START,
                   glyph: 3'h0, fg: 3'h0, bgsel: 1'b0, bgc: 3'h0,
                   vpos: RST_SPR_POS, hpos: RST_SPR_POS, dot_en: 1'b0,
                   div_sel: RST_DIV_SEL, scan: RST_SCAN, ldiv: RST_LINE_DIV,
                   sa: RST_ADDR, ea: RST_END_ADDR, xfer_window_sel: 1'b0, xs: XS_IDLE,
                   addr: RST_ADDR, xend: RST_END_ADDR, xvbs: 1'b0, dcnt: 3'h0,
                   dot: 1'b0, h_dots: H_START_OFFSET, code: SPRITE_CODE_BASE,
                   v_dots: 10'h000, h_dots_spr: 10'h000, spr_en: 1'b0,
                   lratio: 11'h000};
        end else begin
            r <= n;
        end
    end

    // Output assignments, all from the state register; the strobe and busy are decoded from the transfer state.
    assign rom_rd_o = (r.xs == XS_READ);
    assign rom_addr_o = r.addr;
    assign h_start_pos_o = r.h_start;
    assign h_start_dots_o = r.h_dots;
    assign sprite_glyph_code_o = r.code;
    assign sprite_fg_color_o = r.fg;
    assign sprite_bg_select_o = r.bgsel;
    assign sprite_bg_color_o = r.bgc;
    assign sprite_v_pos_o = r.vpos;
    assign sprite_h_pos_o = r.hpos;
    assign sprite_v_dots_o = r.v_dots;
    assign sprite_h_dots_o = r.h_dots_spr;
    assign sprite_enable_o = r.spr_en;
    assign dotclk_o = r.dot;
    assign pixclk_div_sel_o = r.div_sel;
    assign scan_type_sel_o = r.scan;
    assign line_freq_divisor_o = r.ldiv;
    assign line_div_ratio_o = r.lratio;
    assign xfer_window_sel_o = r.xfer_window_sel;
    assign xfer_busy_out_o = (r.xs != XS_IDLE);

endmodule // opssc_cmd_top

//--- design/opssc_pkg.sv
// Shared constants and types for the display command interpreter.
package opssc_pkg;

    // First-byte opcode values and the masks that pick out their fixed bits.
    localparam logic [7:0] OPC_HSTART = 8'hBC;
    localparam logic [7:0] OPM_HSTART = 8'hFF;
    localparam logic [7:0] OPC_SPRITE = 8'hD0;
    localparam logic [7:0] OPM_SPRITE = 8'hF0;
    localparam logic [7:0] OPC_SPR_V = 8'hC8;
    localparam logic [7:0] OPM_SPR_V = 8'hFC;
    localparam logic [7:0] OPC_SPR_H = 8'hCC;
    localparam logic [7:0] OPM_SPR_H = 8'hFC;
    localparam logic [7:0] OPC_SYNC1 = 8'hB0;
    localparam logic [7:0] OPM_SYNC1 = 8'hFE;
    localparam logic [7:0] OPC_SYNC2 = 8'hB4;
    localparam logic [7:0] OPM_SYNC2 = 8'hFF;
    localparam logic [7:0] OPC_SA_LO = 8'hA0;
    localparam logic [7:0] OPC_SA_HI = 8'hA4;
    localparam logic [7:0] OPC_EA_LO = 8'hA8;
    localparam logic [7:0] OPM_ADDR = 8'hFF;
    localparam logic [7:0] OPC_EA_HI = 8'hAC;
    localparam logic [7:0] OPM_EA_HI = 8'hFE;

    // Field positions inside the command bytes.
    localparam int GLYPH_MSB = 3;
    localparam int BGSEL_BIT = 0;
    localparam int FG_MSB = 6;
    localparam int BGC_MSB = 2;
    localparam int DOT_BIT = 0;
    localparam int VBS_BIT = 0;

    // Display geometry figures in dot clocks, and the sprite character code base.
    localparam logic [10:0] H_START_OFFSET = 11'h064;
    localparam logic [8:0] SPRITE_CODE_BASE = 9'h1F8;
    localparam logic [8:0] SPRITE_H_OFF = 9'h000;

    // Scan mode that may never be written.
    localparam logic [1:0] SCAN_PROHIBITED = 2'b11;

    // Prescaler ratios for each select value.
    localparam logic [2:0] PRESC_DIV0 = 3'h2;
    localparam logic [2:0] PRESC_DIV1 = 3'h3;
    localparam logic [2:0] PRESC_DIV2 = 3'h5;
    localparam logic [2:0] PRESC_DIV3 = 3'h6;

    // Values after reset.
    localparam logic [6:0] RST_H_START = 7'h00;
    localparam logic [8:0] RST_SPR_POS = 9'h000;
    localparam logic [1:0] RST_DIV_SEL = 2'b00;
    localparam logic [1:0] RST_SCAN = 2'b01;
    localparam logic [6:0] RST_LINE_DIV = 7'h00;
    localparam logic [15:0] RST_ADDR = 16'h0000;
    localparam logic [15:0] RST_END_ADDR = 16'h0001;

    // Command-table transfer states, Gray coded from idle through take; take back to wait flips both bits.
    typedef enum logic [1:0] {
        XS_IDLE = 2'b00,
        XS_WAIT = 2'b01,
        XS_READ = 2'b11,
        XS_TAKE = 2'b10
    } opssc_xs_t;

endpackage

//--- design/opssc_serial_rx.sv
// Serial byte receiver for the three-wire host command port.
`timescale 1ns/1ps
module opssc_serial_rx
    import opssc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Host serial pins.
    input wire logic scs_n_i,
    input wire logic sclk_i,
    input wire logic sdata_i,
    // Received bytes.
    output logic cs_active_o,
    output logic byte_valid_o,
    output logic [7:0] byte_o
);

    // All receiver state in one record.
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic sclk_d;
        logic [2:0] cnt;
        logic [7:0] shift;
        logic valid;
        logic [7:0] data;
    } opssc_rx_t;

    opssc_rx_t r;
    opssc_rx_t n;

    // Next-state logic; only the second synchroniser stage is examined.
    always_comb begin
        n = r;
        n.s1 = {scs_n_i, sclk_i, sdata_i};
        n.s2 = r.s1;
        n.sclk_d = r.s2[1];
        n.valid = 1'b0;
        // Chip select high aborts any partial byte.
        if (r.s2[2]) begin
            n.cnt = 3'h0;
        end else if (r.s2[1] && !r.sclk_d) begin
            // Rising serial clock: shift in one bit, MSB first.
            n.shift = {r.shift[6:0], r.s2[0]};
            n.cnt = r.cnt + 3'h1;
            if (r.cnt == 3'h7) begin
                n.valid = 1'b1;
                n.data = {r.shift[6:0], r.s2[0]};
            end
        end
    end

    // State register.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '{s1: 3'b110, s2: 3'b110, sclk_d: 1'b1, cnt: 3'h0, shift: 8'h00,
                   valid: 1'b0, data: 8'h00};
        end else begin
            r <= n;
        end
    end

    assign cs_active_o = !r.s2[2];
    assign byte_valid_o = r.valid;
    assign byte_o = r.data;

endmodule // opssc_serial_rx

//--- tb/opssc_cmd_chk.sv
// Concurrent checks on the outputs of the display command interpreter.
`timescale 1ns/1ps
module opssc_cmd_chk (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Table memory port.
    input wire logic rom_rd_o,
    input wire logic [15:0] rom_addr_o,
    // Decoded settings.
    input wire logic [6:0] h_start_pos_o,
    input wire logic [10:0] h_start_dots_o,
    input wire logic [8:0] sprite_glyph_code_o,
    input wire logic [8:0] sprite_v_pos_o,
    input wire logic [8:0] sprite_h_pos_o,
    input wire logic [9:0] sprite_v_dots_o,
    input wire logic [9:0] sprite_h_dots_o,
    input wire logic sprite_enable_o,
    input wire logic [1:0] scan_type_sel_o,
    input wire logic [6:0] line_freq_divisor_o,
    input wire logic [10:0] line_div_ratio_o,
    input wire logic xfer_busy_out_o
);
    // Every check uses the system clock and rests during reset.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // A table read strobe followed by its data-take cycle.
    sequence read_take_s;
        rom_rd_o ##1 !rom_rd_o;
    endsequence

    hstart_dots_a: assert property (
        h_start_dots_o == 11'h064 + {1'b0, h_start_pos_o, 3'b000})
        else $error("horizontal start dots do not follow the field");
    glyph_range_a: assert property (sprite_glyph_code_o[8:3] == 6'h3F)
        else $error("sprite code outside the sprite glyph range");
    vpos_dots_a: assert property (sprite_v_dots_o == {sprite_v_pos_o, 1'b0})
        else $error("sprite vertical dots are not twice the field");
    hpos_dots_a: assert property (sprite_h_dots_o == {sprite_h_pos_o, 1'b0})
        else $error("sprite horizontal dots are not twice the field");
    sprite_hide_a: assert property (
        sprite_enable_o == (sprite_h_pos_o != 9'h000))
        else $error("sprite enable does not match horizontal position");
    scan_legal_a: assert property (scan_type_sel_o != 2'b11)
        else $error("prohibited scan value was taken");
    line_ratio_a: assert property (
        line_div_ratio_o == {line_freq_divisor_o, 4'b0000})
        else $error("line ratio is not sixteen times the divisor");
    start_even_a: assert property ($rose(xfer_busy_out_o) |-> !rom_addr_o[0])
        else $error("transfer began at an odd address");
    read_busy_a: assert property (rom_rd_o |-> xfer_busy_out_o)
        else $error("table read outside a transfer");
    read_step_a: assert property (
        read_take_s |=> (!xfer_busy_out_o || rom_addr_o == $past(rom_addr_o, 2) + 16'h0001))
        else $error("table address did not step by one");
endmodule // opssc_cmd_chk

bind opssc_cmd_top opssc_cmd_chk i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .rom_rd_o(rom_rd_o), .rom_addr_o(rom_addr_o), .h_start_pos_o(h_start_pos_o),
    .h_start_dots_o(h_start_dots_o), .sprite_glyph_code_o(sprite_glyph_code_o),
    .sprite_v_pos_o(sprite_v_pos_o), .sprite_h_pos_o(sprite_h_pos_o),
    .sprite_v_dots_o(sprite_v_dots_o), .sprite_h_dots_o(sprite_h_dots_o),
    .sprite_enable_o(sprite_enable_o), .scan_type_sel_o(scan_type_sel_o),
    .line_freq_divisor_o(line_freq_divisor_o), .line_div_ratio_o(line_div_ratio_o),
    .xfer_busy_out_o(xfer_busy_out_o));

//--- tb/opssc_host_model.sv
// Host controller model that sends command pairs over the three-wire port.
`timescale 1ns/1ps
module opssc_host_model (
    // Clock used to pace the serial edges.
    input wire logic clk_i,
    // Serial pins toward the interpreter.
    output logic scs_n_o,
    output logic sclk_o,
    output logic sdata_o
);
    // The serial clock idles high and stands still between frames.
    initial begin
        scs_n_o = 1'b1;
        sclk_o = 1'b1;
        sdata_o = 1'b0;
    end

    // No field parity line exists on this block, so has nothing to drive here.
    // sixteen-bit frames
    // One frame carries both bytes, since a deselect drops a pending first byte.
    task automatic send(input logic [7:0] b1, input logic [7:0] b2, input int half);
        logic [15:0] w;
        w = {b1, b2};
        @(negedge clk_i);
        scs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sclk_o = 1'b0;
            sdata_o = w[i];
            repeat (half) @(negedge clk_i);
            sclk_o = 1'b1;
            repeat (half) @(negedge clk_i);
        end
        scs_n_o = 1'b1;
        // A released data line shows no stale bit.
        sdata_o = ~sdata_o;
    endtask
endmodule // opssc_host_model

//--- tb/tb.sv
// Self-checking testbench for the display command interpreter.
`timescale 1ns/1ps
module tb;
    // Pins and outputs of the design.
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic scs_n, sclk, sdata, hblank = 1'b0, vblank = 1'b0, rom_rd, busy, dotclk, sp_en, bgsel;
    logic [15:0] rom_addr, first_a, last_a;
    logic [7:0] rom_data = 8'h00;
    logic [7:0] mem [0:7];
    logic [6:0] hpos, ldiv;
    logic [10:0] hdots, lratio;
    logic [8:0] glyph, vpos, spx;
    logic [9:0] vdots, hdts;
    logic [2:0] fg, bgc;
    logic [1:0] psel, scan;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int nrd = 0;
    int per;
    logic busy_seen = 1'b0;
    logic rd_hold = 1'b0; // Read data is held through the cycle after the strobe.
    logic xsel;           // Transfer window select as shown by the design.

    opssc_cmd_top i_dut (.clk_i(clk), .reset_n_i(reset_n), .scs_n_i(scs_n), .sclk_i(sclk),
        .sdata_i(sdata), .hblank_i(hblank), .vblank_i(vblank), .rom_rd_o(rom_rd),
        .rom_addr_o(rom_addr), .rom_data_i(rom_data), .h_start_pos_o(hpos),
        .h_start_dots_o(hdots), .sprite_glyph_code_o(glyph), .sprite_fg_color_o(fg),
        .sprite_bg_select_o(bgsel), .sprite_bg_color_o(bgc), .sprite_v_pos_o(vpos),
        .sprite_h_pos_o(spx), .sprite_v_dots_o(vdots), .sprite_h_dots_o(hdts),
        .sprite_enable_o(sp_en), .dotclk_o(dotclk), .pixclk_div_sel_o(psel),
        .scan_type_sel_o(scan), .line_freq_divisor_o(ldiv), .line_div_ratio_o(lratio),
        .xfer_window_sel_o(xsel), .xfer_busy_out_o(busy));
    opssc_host_model i_host (.clk_i(clk), .scs_n_o(scs_n), .sclk_o(sclk), .sdata_o(sdata));

    // The 50 MHz system clock.
    always #10 clk = ~clk;

    // Table memory drives data during the strobe, holds it through the data-take
    // cycle that follows and scrambles its bus otherwise.
    always @(negedge clk) begin
        if (rom_rd === 1'b1) rom_data <= mem[rom_addr[2:0]];
        else if (!rd_hold) rom_data <= ~rom_data;
        rd_hold <= (rom_rd === 1'b1);
        if (rom_rd === 1'b1) begin
            if (nrd == 0) first_a = rom_addr;
            last_a = rom_addr;
            nrd++;
        end
        if (busy === 1'b1) busy_seen = 1'b1;
    end

    // A hang is cut short after a fixed number of cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            conclude();
        end
    end

    // Prints the verdict and ends the run.
    task automatic conclude();
        if (miscompares == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Compares one settled value with its expectation.
    task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Sends one command pair and lets the settings land.
    task automatic send(input logic [7:0] b1, input logic [7:0] b2, input int half = 4);
        i_host.send(b1, b2, half);
        repeat (8) @(negedge clk);
    endtask

    // Measures one full dot clock period in system cycles.
    task automatic dot_period(output int n);
        int k;
        for (k = 0; k < 40 && dotclk !== 1'b0; k++) @(negedge clk);
        for (k = 0; k < 40 && dotclk !== 1'b1; k++) @(negedge clk);
        n = 0;
        while (n < 40 && dotclk === 1'b1) begin @(negedge clk); n++; end
        while (n < 40 && dotclk === 1'b0) begin @(negedge clk); n++; end
    endtask

    // Runs one table transfer over addresses two to five.
    task automatic xfer(input logic xfer_window_sel);
        int k;
        send(8'hBC, 8'h00);
        send(8'hB4, 8'h00);
        hblank = 1'b1;
        vblank = 1'b0;
        nrd = 0;
        busy_seen = 1'b0;
        send(8'hA0, 8'h03);
        send(8'hA4, 8'h00);
        send(8'hA8, 8'h04);
        cmp("busy_before_end", 16'h0000, {15'h0, busy_seen});
        send(8'hAC | {7'h00, xfer_window_sel}, 8'h00);
        cmp("busy_started", 16'h0001, {15'h0, busy_seen});
        cmp("window_sel", {15'h0, xfer_window_sel}, {15'h0, xsel});
        repeat (20) @(negedge clk);
        // With line blanking allowed, the whole table has run by now.
        cmp("reads_in_hblank", xfer_window_sel ? 16'h0000 : 16'h0004, 16'(nrd));
        vblank = 1'b1;
        for (k = 0; k < 300 && busy !== 1'b0; k++) @(negedge clk);
        cmp("busy_end", 16'h0000, {15'h0, busy});
        cmp("read_count", 16'h0004, 16'(nrd));
        cmp("first_addr", 16'h0002, first_a);
        cmp("last_addr", 16'h0005, last_a);
        cmp("table_hstart", 16'h0011, {9'h0, hpos});
        cmp("table_ratio", 16'h02A0, {5'h0, lratio});
        vblank = 1'b0;
        hblank = 1'b0;
    endtask

    // Main sequence of tests.
    initial begin
        mem = '{8'h00, 8'h00, 8'hBC, 8'h11, 8'hB4, 8'h2A, 8'h00, 8'h00};
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        cmp("rst_sprite_en", 16'h0000, {15'h0, sp_en});
        cmp("rst_busy", 16'h0000, {15'h0, busy});
        cmp("rst_hdots", 16'h0064, {5'h0, hdots});
        cmp("rst_glyph", 16'h01F8, {7'h0, glyph});
        foreach (mem[v]) begin
            send(8'hBC, {1'b0, 7'(v * 18)});
            cmp("hstart", 16'(v * 18), {9'h0, hpos});
            cmp("hdots", 16'(100 + 8 * (v * 18)), {5'h0, hdots});
        end
        for (int g = 0; g < 8; g++) begin
            send(8'hD0 | 8'(g << 1) | 8'(g & 1), {1'b0, 3'(g), 1'b0, 3'(7 - g)}, 4 + g);
            cmp("glyph", 16'(16'h01F8 + g), {7'h0, glyph});
            cmp("bgsel", 16'(g & 1), {15'h0, bgsel});
            cmp("fg_bg", 16'((g << 3) | (7 - g)), {10'h0, fg, bgc});
        end
        send(8'hCB, 8'h7F);
        cmp("vpos", 16'h01FF, {7'h0, vpos});
        cmp("vdots", 16'h03FE, {6'h0, vdots});
        send(8'hCE, 8'h55);
        cmp("hpos", 16'h0155, {7'h0, spx});
        cmp("hdots_spr", 16'h02AA, {6'h0, hdts});
        cmp("sprite_on", 16'h0001, {15'h0, sp_en});
        send(8'hCC, 8'h00);
        cmp("sprite_off", 16'h0000, {15'h0, sp_en});
        cmp("vpos_held", 16'h01FF, {7'h0, vpos});
        for (int p = 0; p < 4; p++) begin
            send(8'hB1, {4'h0, 2'(p), 2'b10});
            dot_period(per);
            cmp("dot_period", 16'(p == 0 ? 2 : p == 1 ? 3 : p == 2 ? 5 : 6), 16'(per));
            cmp("scan_step", 16'h0002, {14'h0, scan});
        end
        send(8'hB0, 8'h00);
        repeat (20) begin
            @(negedge clk);
            cmp("dot_gated", 16'h0000, {15'h0, dotclk});
        end
        cmp("scan_inter", 16'h0000, {14'h0, scan});
        send(8'hB0, 8'h07);
        cmp("scan_refused", 16'h0000, {14'h0, scan});
        cmp("presc_loaded", 16'h0001, {14'h0, psel});
        send(8'hB0, 8'h01);
        cmp("scan_nonint", 16'h0001, {14'h0, scan});
        send(8'hB4, 8'h7F);
        cmp("line_ratio", 16'h07F0, {5'h0, lratio});
        cmp("line_div", 16'h007F, {9'h0, ldiv});
        xfer(1'b1);
        xfer(1'b0);
        conclude();
    end
endmodule // tb
